/* nfh_bbt_mem.sv */
// bad block table memory, one bit per block, registered read
`timescale 1ns/1ps
module nfh_bbt_mem (
  // clock
  input wire logic i_sys_clk,
  // write port
  input wire logic i_we,
  input wire logic [10:0] i_waddr,
  input wire logic i_wbit,
  // read port
  input wire logic [10:0] i_raddr,
  output logic o_rbit
);
  logic mem [0:2047];

  // table starts with every block good; entries are only ever set
  initial begin
    for (int k = 0; k < 2048; k++) begin
      mem[k] = 1'b0;
    end
  end

  // table storage, no reset so it maps to ram
  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wbit;
    end
    o_rbit <= mem[i_raddr];
  end
endmodule

/* nfh_ctrl.sv */
// host controller for an 8-bit nand with on-die ecc
`timescale 1ns/1ps
module nfh_ctrl (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // user request
  input wire logic i_req_valid,
  input wire nfh_pkg::nfh_req_t i_req,
  input wire logic i_ecc_on,
  output logic o_req_ready,
  // write data stream
  input wire logic [7:0] i_wdata,
  output logic o_wdata_take,
  // read data stream
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  // completion
  output logic o_done,
  output logic o_fail,
  output logic o_refused,
  output logic o_bad_block,
  output logic [11:0] o_bad_count,
  output logic o_below_min,
  // nand pins
  output nfh_pkg::nfh_pins_t o_pins,
  input wire logic [7:0] i_dq,
  input wire logic i_rb
);
  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_CMD = 9'h002, S_ADDR = 9'h004, S_WDAT = 9'h008,
    S_CMD2 = 9'h010, S_WAIT = 9'h020, S_STAT = 9'h040, S_RCMD = 9'h080,
    S_RDAT = 9'h100
  } nfh_st_t;

  nfh_st_t st_r, st_nxt;
  nfh_pkg::nfh_req_t req_r;
  logic ecc_r;
  logic [2:0] step_r;
  logic [2:0] acnt_r;
  logic [12:0] cnt_r;
  logic [7:0] dq_s1_r, dq_s2_r;
  logic rb_s1_r, rb_s2_r;
  logic [2:0] nproc_r [0:3];
  logic [1:0] pp_idx_r;
  logic [16:0] pp_row_r [0:3];
  logic [2:0] pp_cnt_r [0:3];
  logic scan_pg_r;
  logic [11:0] bad_cnt_r;
  logic bbt_rbit;

  // two-flop sync of device pins
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
      rb_s1_r <= 1'b0;
      rb_s2_r <= 1'b0;
    end else begin
      dq_s1_r <= i_dq;
      dq_s2_r <= dq_s1_r;
      rb_s1_r <= i_rb;
      rb_s2_r <= rb_s1_r;
    end
  end

  // request checks
  wire [12:0] col_end = 13'(i_req.col + i_req.len - 13'h0001);
  wire hits_parity = i_ecc_on && (col_end >= nfh_pkg::COL_PAR0)
    && (i_req.col <= nfh_pkg::COL_PAR_LAST);
  wire [2:0] sec_a = i_req.col[11:9];
  wire in_main = i_req.col <= nfh_pkg::COL_MAIN_LAST;
  wire split_sector = i_ecc_on && in_main && (i_req.col[8:0] != 9'h000
    || i_req.len[8:0] != 9'h000);
  wire [16:0] blk_row = {i_req.row[16:nfh_pkg::PAGE_BITS], 6'h00};
  wire pp_hit = pp_row_r[0] == i_req.row || pp_row_r[1] == i_req.row
    || pp_row_r[2] == i_req.row || pp_row_r[3] == i_req.row;
  wire [1:0] pp_sel = (pp_row_r[0] == i_req.row) ? 2'd0 :
    (pp_row_r[1] == i_req.row) ? 2'd1 : (pp_row_r[2] == i_req.row) ? 2'd2 : 2'd3;
  wire pp_full = pp_hit && pp_cnt_r[pp_sel] >= 3'(nfh_pkg::MAX_PARTIAL);
  wire is_prog = i_req.op == nfh_pkg::OP_PROG;
  wire is_wr = is_prog || i_req.op == nfh_pkg::OP_ERASE;
  wire refuse = (is_prog && (hits_parity || split_sector || pp_full))
    || (is_wr && bbt_rbit);
  wire accept = st_r == S_IDLE && i_req_valid;
  // read cycles run one cycle longer so the byte has crossed the synchroniser
  localparam int RD_SYNC_CYC = 1;
  wire rd_cyc = st_r == S_RDAT || (st_r == S_STAT && acnt_r == 3'd1);
  wire [2:0] strobe_len = rd_cyc ? 3'(nfh_pkg::T_STROBE_CYC * 2 + RD_SYNC_CYC)
    : 3'(nfh_pkg::T_STROBE_CYC * 2);
  wire strobe_end = step_r == strobe_len;
  wire busy_done = rb_s2_r && step_r == 3'(nfh_pkg::T_WB_CYC);
  wire is_read_op = req_r.op == nfh_pkg::OP_READ || req_r.op == nfh_pkg::OP_BBSCAN;
  wire [2:0] naddr = (req_r.op == nfh_pkg::OP_ERASE) ? 3'd3 : 3'd5;
  wire [7:0] addr_byte = (req_r.op == nfh_pkg::OP_ERASE) ?
    ((acnt_r == 3'd0) ? req_r.row[7:0] : (acnt_r == 3'd1) ? req_r.row[15:8] :
    {7'h00, req_r.row[16]}) :
    ((acnt_r == 3'd0) ? req_r.col[7:0] : (acnt_r == 3'd1) ? {3'h0, req_r.col[12:8]} :
    (acnt_r == 3'd2) ? req_r.row[7:0] : (acnt_r == 3'd3) ? req_r.row[15:8] :
    {7'h00, req_r.row[16]});
  wire scan_bad = dq_s2_r == nfh_pkg::BAD_MARK;

  nfh_bbt_mem u_bbt (
    .i_sys_clk(i_sys_clk),
    .i_we(o_bad_block),
    .i_waddr(req_r.row[16:6]),
    .i_wbit(1'b1),
    .i_raddr(i_req.row[16:6]),
    .o_rbit(bbt_rbit)
  );

  // next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      S_IDLE: if (i_req_valid && !refuse && step_r != 3'd0) st_nxt = S_CMD;
      S_CMD: if (strobe_end) st_nxt = S_ADDR;
      S_ADDR: if (strobe_end && acnt_r == naddr - 3'd1)
        st_nxt = (req_r.op == nfh_pkg::OP_PROG) ? S_WDAT : S_CMD2;
      S_WDAT: if (strobe_end && cnt_r == req_r.len - 13'h0001) st_nxt = S_CMD2;
      S_CMD2: if (strobe_end) st_nxt = S_WAIT;
      S_WAIT: if (busy_done) st_nxt = S_STAT;
      S_STAT: if (strobe_end && acnt_r == 3'd1)
        st_nxt = is_read_op ? S_RCMD : S_IDLE;
      S_RCMD: if (strobe_end) st_nxt = S_RDAT;
      S_RDAT: if (strobe_end && cnt_r == req_r.len - 13'h0001) st_nxt = S_IDLE;
    endcase
  end

  // state, counters, and request capture
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= S_IDLE;
      req_r <= '0;
      ecc_r <= 1'b0;
      step_r <= 3'd0;
      acnt_r <= 3'd0;
      cnt_r <= 13'h0000;
      scan_pg_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (st_r == S_IDLE) begin
        // one idle cycle lets the table read settle
        step_r <= (i_req_valid && step_r == 3'd0) ? 3'd1 : 3'd0;
        if (st_nxt == S_CMD) begin
          req_r <= i_req;
          ecc_r <= i_ecc_on;
          scan_pg_r <= 1'b0;
          if (i_req.op == nfh_pkg::OP_BBSCAN) begin
            req_r.row <= blk_row;
            req_r.col <= nfh_pkg::COL_BBM;
            req_r.len <= 13'h0001;
          end
          step_r <= 3'd0;
          acnt_r <= 3'd0;
          cnt_r <= 13'h0000;
        end
      end else if (st_r == S_WAIT) begin
        step_r <= busy_done ? 3'd0 : (step_r == 3'(nfh_pkg::T_WB_CYC) ? step_r : step_r + 3'd1);
        acnt_r <= 3'd0;
      end else begin
        step_r <= strobe_end ? 3'd0 : step_r + 3'd1;
        if (strobe_end) begin
          acnt_r <= (st_nxt != st_r) ? 3'd0 : acnt_r + 3'd1;
          cnt_r <= (st_nxt != st_r) ? 13'h0000 : cnt_r + 13'h0001;
        end
        // second page of a scan re-runs the read on page one
        if (st_r == S_RDAT && st_nxt == S_IDLE && req_r.op == nfh_pkg::OP_BBSCAN
            && !scan_pg_r && !scan_bad) begin
          st_r <= S_CMD;
          scan_pg_r <= 1'b1;
          req_r.row <= req_r.row + 17'h00001;
        end
      end
    end
  end

  // pins and user outputs
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pins <= '{nce: 1'b1, cle: 1'b0, ale: 1'b0, nwe: 1'b1, nre: 1'b1, dq: 8'h00, dq_oe: 1'b0};
      o_req_ready <= 1'b0;
      o_wdata_take <= 1'b0;
      o_rdata <= 8'h00;
      o_rdata_valid <= 1'b0;
      o_done <= 1'b0;
      o_fail <= 1'b0;
      o_refused <= 1'b0;
    end else begin
      o_pins.nce <= st_nxt == S_IDLE;
      o_pins.cle <= st_r == S_CMD || st_r == S_CMD2 || st_r == S_RCMD
        || (st_r == S_STAT && acnt_r == 3'd0);
      o_pins.ale <= st_r == S_ADDR;
      o_pins.nwe <= !((st_r == S_CMD || st_r == S_ADDR || st_r == S_WDAT
        || st_r == S_CMD2 || st_r == S_RCMD || (st_r == S_STAT && acnt_r == 3'd0))
        && step_r < 3'(nfh_pkg::T_STROBE_CYC));
      o_pins.nre <= !((st_r == S_RDAT || (st_r == S_STAT && acnt_r == 3'd1))
        && step_r < 3'(nfh_pkg::T_STROBE_CYC));
      o_pins.dq_oe <= st_r == S_CMD || st_r == S_ADDR || st_r == S_WDAT
        || st_r == S_CMD2 || st_r == S_RCMD || (st_r == S_STAT && acnt_r == 3'd0);
      unique case (st_r)
        S_CMD: o_pins.dq <= (req_r.op == nfh_pkg::OP_PROG) ? nfh_pkg::CMD_PROG1 :
          (req_r.op == nfh_pkg::OP_ERASE) ? nfh_pkg::CMD_ERASE1 : nfh_pkg::CMD_READ1;
        S_ADDR: o_pins.dq <= addr_byte;
        S_WDAT: o_pins.dq <= (step_r == 3'd0) ? i_wdata : o_pins.dq; // held across the strobe
        S_CMD2: o_pins.dq <= (req_r.op == nfh_pkg::OP_PROG) ? nfh_pkg::CMD_PROG2 :
          (req_r.op == nfh_pkg::OP_ERASE) ? nfh_pkg::CMD_ERASE2 : nfh_pkg::CMD_READ2;
        S_STAT: o_pins.dq <= nfh_pkg::CMD_STATUS;
        S_RCMD: o_pins.dq <= nfh_pkg::CMD_READ1;
        default: o_pins.dq <= o_pins.dq;
      endcase
      o_req_ready <= accept && step_r != 3'd0 && !refuse;
      o_refused <= accept && step_r != 3'd0 && refuse;
      o_wdata_take <= st_r == S_WDAT && step_r == 3'd0; // next byte lands before next strobe
      // sample read data once it has crossed the synchroniser; data is already corrected
      o_rdata_valid <= st_r == S_RDAT && strobe_end && req_r.op == nfh_pkg::OP_READ;
      o_rdata <= dq_s2_r;
      o_done <= st_r != S_IDLE && st_nxt == S_IDLE
        && !(st_r == S_RDAT && req_r.op == nfh_pkg::OP_BBSCAN && !scan_pg_r && !scan_bad);
      // fail bit: uncorrectable on read with ecc, program or erase fail otherwise
      if (st_r == S_STAT && strobe_end && acnt_r == 3'd1) begin
        o_fail <= dq_s2_r[nfh_pkg::SR_FAIL] && (!is_read_op || ecc_r);
      end else if (st_r == S_CMD) begin
        o_fail <= 1'b0;
      end
    end
  end

  // partial program tracking and bad block bookkeeping
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pp_idx_r <= 2'd0;
      bad_cnt_r <= 12'h000;
      o_bad_block <= 1'b0;
      o_bad_count <= 12'h000;
      o_below_min <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        pp_row_r[k] <= '1;
        pp_cnt_r[k] <= 3'd0;
      end
    end else begin
      if (accept && step_r != 3'd0 && !refuse) begin
        if (is_prog) begin
          if (pp_hit) begin
            pp_cnt_r[pp_sel] <= pp_cnt_r[pp_sel] + 3'd1;
          end else begin
            pp_row_r[pp_idx_r] <= i_req.row;
            pp_cnt_r[pp_idx_r] <= 3'd1;
            pp_idx_r <= pp_idx_r + 2'd1;
          end
        end
        if (i_req.op == nfh_pkg::OP_ERASE) begin
          for (int k = 0; k < 4; k++) begin
            if (pp_row_r[k][16:6] == i_req.row[16:6]) pp_cnt_r[k] <= 3'd0;
          end
        end
      end
      o_bad_block <= (st_r == S_STAT && strobe_end && acnt_r == 3'd1 && !is_read_op
        && dq_s2_r[nfh_pkg::SR_FAIL])
        || (st_r == S_RDAT && strobe_end && req_r.op == nfh_pkg::OP_BBSCAN && scan_bad);
      if (o_bad_block) bad_cnt_r <= bad_cnt_r + 12'h001;
      o_bad_count <= bad_cnt_r;
      o_below_min <= (nfh_pkg::TOTAL_BLOCKS - bad_cnt_r) < nfh_pkg::min_valid_block_count;
    end
  end
endmodule

/* nfh_ctrl_assertions.sv */
// checker for the nand host controller pins and handshakes
`timescale 1ns/1ps
module nfh_ctrl_assertions (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // handshakes
  input wire logic i_req_valid,
  input wire logic o_req_ready,
  input wire logic o_refused,
  input wire logic o_done,
  input wire logic o_fail,
  input wire logic o_rdata_valid,
  // nand side
  input wire logic [7:0] i_dq,
  input wire logic i_rb,
  input wire nfh_pkg::nfh_pins_t o_pins
);
  logic nwe_q, smode, sread, pend, sb0;
  logic cmd_w, cmd_end, stat_rd;
  // command latch edge, end of a program or erase command, status byte on the bus
  assign cmd_w = o_pins.cle && o_pins.nwe && !nwe_q;
  assign cmd_end = cmd_w && (o_pins.dq == nfh_pkg::CMD_PROG2 || o_pins.dq == nfh_pkg::CMD_ERASE2);
  assign stat_rd = smode && !o_pins.nre;
  // status mode, status seen, pending program or erase
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      nwe_q <= 1'b1;
      smode <= 1'b0;
      sread <= 1'b0;
      pend <= 1'b0;
      sb0 <= 1'b0;
    end else begin
      nwe_q <= o_pins.nwe;
      if (cmd_w) smode <= (o_pins.dq == nfh_pkg::CMD_STATUS);
      if (cmd_end || stat_rd) sread <= stat_rd;
      if (cmd_end || o_done) pend <= cmd_end;
      if (stat_rd) sb0 <= i_dq[0];
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  we_pulse_a: assert property ($fell(o_pins.nwe) |=> o_pins.nwe)
    else $error("write strobe low too long");
  re_pulse_a: assert property ($fell(o_pins.nre) |=> o_pins.nre)
    else $error("read strobe low too long");
  strobe_sel_a: assert property ((!o_pins.nwe || !o_pins.nre) |-> !o_pins.nce)
    else $error("strobe without chip enable");
  no_contend_a: assert property (!o_pins.nre |-> !o_pins.dq_oe)
    else $error("host drives bus during read");
  cle_ale_a: assert property (!(o_pins.cle && o_pins.ale))
    else $error("command and address latch together");
  req_answer_a: assert property ($rose(i_req_valid) |-> ##[1:3] (o_req_ready || o_refused))
    else $error("request not answered");
  data_mode_a: assert property (o_rdata_valid |-> !smode)
    else $error("data taken in status mode");
  busy_wait_a: assert property (!i_rb |-> o_pins.nre)
    else $error("read strobe while device busy");
  done_status_a: assert property (o_done && pend |-> sread)
    else $error("done without status read");
  fail_status_a: assert property (o_done && pend |-> o_fail == sb0)
    else $error("fail differs from status bit");
endmodule

/* nfh_dev_model.sv */
// behavioural nand die with on-die ecc, answering the host pins
`timescale 1ns/1ps
module nfh_dev_model #(
  parameter int BUSY_NS = 2000,
  parameter logic [10:0] BAD_BLK = 11'h005
) (
  // pins from the host
  input wire nfh_pkg::nfh_pins_t i_pins,
  // error injection
  input wire logic i_ecc_on,
  input wire logic i_uncorr,
  input wire logic i_pfail,
  // toward the host
  output logic [7:0] o_dq,
  output logic o_rb
);
  logic [7:0] mem [logic [29:0]];
  logic [29:0] kq[$];
  logic [12:0] col;
  logic [16:0] row;
  logic [7:0] dq;
  logic smode, sfail;
  logic [7:0] par;
  logic [12:0] pc;
  int ac;
  // erased array with the factory mark on one block
  initial begin
    o_rb = 1'b1;
    o_dq = 8'h00;
    smode = 1'b0;
    sfail = 1'b0;
    ac = 0;
    mem[{BAD_BLK, 6'h00, nfh_pkg::COL_BBM}] = nfh_pkg::BAD_MARK;
  end
  // command, address and data cycles latch on the write strobe rising
  always @(posedge i_pins.nwe) begin
    dq = i_pins.dq;
    if (!i_pins.nce && i_pins.cle) begin
      smode = (dq == nfh_pkg::CMD_STATUS);
      if (dq == nfh_pkg::CMD_READ1 || dq == nfh_pkg::CMD_PROG1) ac = 0;
      if (dq == nfh_pkg::CMD_ERASE1) ac = 2;
      if (dq == nfh_pkg::CMD_READ2) sfail = i_ecc_on && i_uncorr;
      if (dq == nfh_pkg::CMD_PROG2 || dq == nfh_pkg::CMD_ERASE2) sfail = i_pfail;
      // parity per sector lands in its own spare slot
      if (dq == nfh_pkg::CMD_PROG2 && i_ecc_on) begin
        for (int s = 0; s < nfh_pkg::SECTORS; s++) begin
          par = 8'h00;
          for (int b = 0; b < nfh_pkg::SECTOR_BYTES; b++) begin
            pc = 13'(s * nfh_pkg::SECTOR_BYTES + b);
            par ^= mem.exists({row, pc}) ? mem[{row, pc}] : 8'hff;
          end
          mem[{row, 13'(nfh_pkg::COL_PAR0 + s * nfh_pkg::PAR_BYTES)}] = par;
        end
      end
      if (dq == nfh_pkg::CMD_ERASE2) begin
        kq.delete();
        foreach (mem[k]) if (k[29:19] == row[16:6]) kq.push_back(k);
        foreach (kq[i]) mem.delete(kq[i]);
      end
      if (dq == nfh_pkg::CMD_READ2 || dq == nfh_pkg::CMD_PROG2 || dq == nfh_pkg::CMD_ERASE2) begin
        o_rb <= #100 1'b0;
        o_rb <= #(100 + BUSY_NS) 1'b1;
      end
    end else if (!i_pins.nce && i_pins.ale) begin
      case (ac)
        0: col[7:0] = dq;
        1: col[12:8] = dq[4:0];
        2: row[7:0] = dq;
        3: row[15:8] = dq;
        default: row[16] = dq[0];
      endcase
      ac++;
    end else if (!i_pins.nce) begin
      mem[{row, col}] = dq;
      col++;
    end
  end
  // data out holds only corrected bytes; status mirrors ready on bit 5
  always @(negedge i_pins.nre) begin
    if (smode) o_dq <= #10 {2'b11, o_rb, 4'h0, sfail};
    else o_dq <= #10 mem.exists({row, col}) ? mem[{row, col}] : 8'hff;
  end
  // released bus shows the inverse of the last byte
  always @(posedge i_pins.nre) begin
    if (!smode) col++;
    o_dq <= #20 ~o_dq;
  end
endmodule

/* nfh_pkg.sv */
// package for the nand host controller: commands, page map, status bits, types
package nfh_pkg;
  // command codes
  localparam logic [7:0] CMD_READ1 = 8'h00;
  localparam logic [7:0] CMD_READ2 = 8'h30;
  localparam logic [7:0] CMD_PROG1 = 8'h80;
  localparam logic [7:0] CMD_PROG2 = 8'h10;
  localparam logic [7:0] CMD_ERASE1 = 8'h60;
  localparam logic [7:0] CMD_ERASE2 = 8'hd0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  // page map
  localparam logic [12:0] COL_MAIN0 = 13'h0000;
  localparam logic [12:0] COL_MAIN_LAST = 13'h0fff;
  localparam logic [12:0] COL_META0 = 13'h1000;
  localparam logic [12:0] COL_META_LAST = 13'h107f;
  localparam logic [12:0] COL_PAR0 = 13'h1080;
  localparam logic [12:0] COL_PAR_LAST = 13'h10ff;
  localparam logic [12:0] COL_BBM = 13'h1000;
  localparam int SECTOR_BYTES = 512;
  localparam int META_BYTES = 16;
  localparam int PAR_BYTES = 16;
  localparam int SECTORS = 8;
  localparam int MAX_PARTIAL = 4;
  localparam logic [7:0] BAD_MARK = 8'h00;
  localparam logic [11:0] TOTAL_BLOCKS = 12'h800;
  localparam logic [11:0] min_valid_block_count = 12'h7d8;
  localparam int PAGE_BITS = 6;
  // status bits
  localparam int SR_FAIL = 0;
  localparam int SR_RDY = 5;
  // pin timing: 20 mhz, 50 ns per cycle
  localparam int CLK_NS = 50;
  localparam int T_WP_NS = 50;
  localparam int T_STROBE_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WB_NS = 200;
  localparam int T_WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
  // operations
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_PROG = 3'h1, OP_ERASE = 3'h2, OP_BBSCAN = 3'h3
  } nfh_op_t;
  // pins driven toward the device
  typedef struct packed {
    logic nce;
    logic cle;
    logic ale;
    logic nwe;
    logic nre;
    logic [7:0] dq;
    logic dq_oe;
  } nfh_pins_t;
  // request from user logic
  typedef struct packed {
    nfh_op_t op;
    logic [16:0] row;
    logic [12:0] col;
    logic [12:0] len;
  } nfh_req_t;
endpackage

/* tb_top.sv */
// self-checking bench for the nand host controller
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errors++; $display("Error %s exp %h got %h", n, e, a); end end
module tb_top;
  logic i_sys_clk, i_nrst, i_req_valid, i_ecc_on, uncorr, pfail, i_rb, rf, fl, bd;
  logic o_req_ready, o_wdata_take, o_rdata_valid, o_done, o_fail, o_refused, o_bad_block;
  logic o_below_min;
  logic [7:0] i_wdata, o_rdata, i_dq;
  logic [11:0] o_bad_count;
  logic [7:0] rq[$];
  nfh_pkg::nfh_req_t i_req;
  nfh_pkg::nfh_pins_t o_pins;
  int errors, checks, cyc, nt;
  nfh_ctrl DUT (.i_sys_clk, .i_nrst, .i_req_valid, .i_req, .i_ecc_on, .o_req_ready, .i_wdata,
    .o_wdata_take, .o_rdata, .o_rdata_valid, .o_done, .o_fail, .o_refused, .o_bad_block,
    .o_bad_count, .o_below_min, .o_pins, .i_dq, .i_rb);
  nfh_dev_model MDL (.i_pins(o_pins), .i_ecc_on, .i_uncorr(uncorr), .i_pfail(pfail), .o_dq(i_dq),
    .o_rb(i_rb));
  // 20 mhz clock and hang guard
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      end_of_test();
    end
  end
  task end_of_test;
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [7:0] pat(input logic [12:0] c);
    return c[7:0] ^ 8'ha5;
  endfunction
  // one operation: request, feed or collect bytes, wait for done
  task automatic run(input nfh_pkg::nfh_op_t op, input logic [16:0] r, input logic [12:0] c,
    input logic [12:0] n);
    logic [12:0] k;
    k = c;
    bd = 1'b0;
    fl = 1'b0;
    rq.delete();
    nt = 0;
    @(posedge i_sys_clk);
    i_req <= '{op, r, c, n};
    i_req_valid <= 1'b1;
    i_wdata <= pat(c);
    do @(negedge i_sys_clk); while (!o_req_ready && !o_refused);
    rf = o_refused;
    @(posedge i_sys_clk);
    i_req_valid <= 1'b0;
    while (!rf) begin
      @(negedge i_sys_clk);
      if (o_rdata_valid) rq.push_back(o_rdata);
      if (o_bad_block) bd = 1'b1;
      fl = o_fail;
      if (o_done) break;
      if (o_wdata_take) begin
        k++;
        nt++;
        @(posedge i_sys_clk);
        i_wdata <= pat(k);
      end
    end
  endtask
  // four partial programs use up a page's program count, a fifth is refused until erase
  task t_partial;
    for (int s = 0; s < 4; s++) begin
      run(nfh_pkg::OP_PROG, 17'h0040, 13'(s * 512), 13'h0200);
      `CHK("prog", 2'b00, {rf, fl})
      `CHK("takes", 512, nt)
    end
    run(nfh_pkg::OP_READ, 17'h0040, 13'h03fc, 13'h0008);
    `CHK("rlen", 8, rq.size())
    for (int i = 0; i < 8; i++) `CHK("rdata", pat(13'h03fc + 13'(i)), rq[i])
    run(nfh_pkg::OP_READ, 17'h0040, nfh_pkg::COL_PAR0 + 13'h0010, 13'h0001);
    `CHK("par", 8'h00, rq[0])
    run(nfh_pkg::OP_PROG, 17'h0040, 13'h0800, 13'h0200);
    `CHK("fifth", 1'b1, rf)
    run(nfh_pkg::OP_ERASE, 17'h0040, 13'h0000, 13'h0000);
    `CHK("erase", 2'b00, {rf, fl})
    run(nfh_pkg::OP_PROG, 17'h0040, 13'h0800, 13'h0200);
    `CHK("reprog", 1'b0, rf)
  endtask
  // parity region and split sector are refused
  task t_refuse;
    run(nfh_pkg::OP_PROG, 17'h0080, nfh_pkg::COL_PAR0, 13'h0010);
    `CHK("parity", 1'b1, rf)
    run(nfh_pkg::OP_PROG, 17'h0080, 13'h0100, 13'h0200);
    `CHK("split", 1'b1, rf)
  endtask
  // uncorrectable read and failed program or erase
  task t_status;
    @(posedge i_sys_clk);
    uncorr <= 1'b1;
    run(nfh_pkg::OP_READ, 17'h0040, 13'h0800, 13'h0004);
    `CHK("rdfail", 1'b1, fl)
    @(posedge i_sys_clk);
    i_ecc_on <= 1'b0;
    run(nfh_pkg::OP_READ, 17'h0040, 13'h0800, 13'h0004);
    `CHK("rdraw", 1'b0, fl)
    `CHK("rdbyte", pat(13'h0800), rq[0])
    @(posedge i_sys_clk);
    i_ecc_on <= 1'b1;
    uncorr <= 1'b0;
    pfail <= 1'b1;
    run(nfh_pkg::OP_PROG, 17'h00c0, 13'h0000, 13'h0200);
    `CHK("pgfail", 1'b1, fl)
    run(nfh_pkg::OP_ERASE, 17'h0100, 13'h0000, 13'h0000);
    `CHK("erfail", 1'b1, fl)
    @(posedge i_sys_clk);
    pfail <= 1'b0;
  endtask
  // factory mark is found, counted and guarded
  task t_scan;
    run(nfh_pkg::OP_BBSCAN, 17'h0080, nfh_pkg::COL_BBM, 13'h0001);
    `CHK("good", 1'b0, bd)
    run(nfh_pkg::OP_BBSCAN, 17'h0140, nfh_pkg::COL_BBM, 13'h0001);
    `CHK("bad", 1'b1, bd)
    // count lags the mark by two cycles; two status failures plus the factory mark
    repeat (2) @(negedge i_sys_clk);
    `CHK("count", 12'h003, o_bad_count)
    `CHK("belowmin", 1'b0, o_below_min)
    run(nfh_pkg::OP_PROG, 17'h0140, 13'h0000, 13'h0200);
    `CHK("badprog", 1'b1, rf)
  endtask
  // reset, then the scenarios
  initial begin
    {errors, checks, cyc} = '0;
    {i_nrst, i_req_valid, uncorr, pfail} = '0;
    i_ecc_on = 1'b1;
    i_req = '0;
    i_wdata = 8'h00;
    repeat (3) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    t_partial();
    t_refuse();
    t_status();
    t_scan();
    end_of_test();
  end
endmodule
bind nfh_ctrl nfh_ctrl_assertions CHKR (.i_sys_clk, .i_nrst, .i_req_valid, .o_req_ready,
  .o_refused, .o_done, .o_fail, .o_rdata_valid, .i_dq, .i_rb, .o_pins);
